// ### rbpc_defines.svh
// Offsets, field positions, reset values and timing counts of the polarity corrector.
`ifndef RBPC_DEFINES_SVH
`define RBPC_DEFINES_SVH

// Clock rate and period.
`define RBPC_CLK_MHZ 250
`define RBPC_CLK_PERIOD_NS 4

// Failsafe idle interval: nominal point inside the 44 ms to 76 ms window.
`define RBPC_FAILSAFE_MIN_US 44000
`define RBPC_FAILSAFE_MAX_US 76000
`define RBPC_FAILSAFE_TIME_US 58000
`define RBPC_FAILSAFE_CYC (`RBPC_FAILSAFE_TIME_US * `RBPC_CLK_MHZ)

// Least disabled time before standby, rounded up to whole cycles.
`define RBPC_STANDBY_TIME_NS 300
`define RBPC_STANDBY_CYC \
	((`RBPC_STANDBY_TIME_NS + `RBPC_CLK_PERIOD_NS - 1) / `RBPC_CLK_PERIOD_NS)

// Register byte offsets.
`define RBPC_CTRL_OFS 8'h00
`define RBPC_STATUS_OFS 8'h04

// Control register fields.
`define RBPC_CTRL_DRIVE_BIT 0
`define RBPC_CTRL_LISTEN_N_BIT 1
`define RBPC_CTRL_TXD_BIT 2
`define RBPC_CTRL_RESET 3'h4

// Status register fields.
`define RBPC_STAT_RXD_BIT 0
`define RBPC_STAT_INV_BIT 1
`define RBPC_STAT_STANDBY_BIT 2
`define RBPC_STAT_LISTEN_BIT 3
`define RBPC_STAT_DECIDED_BIT 4

// AXI responses.
`define RBPC_RESP_OKAY 2'h0
`define RBPC_RESP_SLVERR 2'h2

`endif

// ### rbpc_pkg.sv
// Types shared by the polarity corrector modules.
`default_nettype none
package rbpc_pkg;
	typedef logic [23:0] rbpc_cnt_t;
	typedef logic [7:0] rbpc_addr_t;
	typedef enum logic [1:0] {RBPC_T_COUNT, RBPC_T_DONE} rbpc_tmr_state_e;
endpackage : rbpc_pkg
`default_nettype wire

// ### rbpc_core_if.sv
// Signals between the corrector core, its idle timer and its standby filter.
`timescale 1ns/1ps
`default_nettype none
interface rbpc_core_if;
	logic restart;
	logic expired;
	logic dis_req;
	logic standby;
	modport tmr (input restart, output expired);
	modport sby (input dis_req, output standby);
	modport core (output restart, output dis_req, input expired, input standby);
endinterface : rbpc_core_if
`default_nettype wire

// ### rbpc_idle_timer.sv
// Failsafe idle timer: one pulse after an unbroken run of listening idle.
`timescale 1ns/1ps
`default_nettype none
module rbpc_idle_timer #(
	parameter int unsigned LIMIT = 1000
) (
	input wire logic aclk,
	input wire logic aresetn,
	rbpc_core_if.tmr tif
);
	import rbpc_pkg::*;

	rbpc_tmr_state_e state_reg;
	rbpc_cnt_t cnt_reg;
	rbpc_cnt_t run_reg;

	// Any restart clears the count, so only uninterrupted idle reaches the limit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= RBPC_T_COUNT;
			cnt_reg <= '0;
			tif.expired <= 1'b0;
		end else if (tif.restart) begin
			state_reg <= RBPC_T_COUNT;
			cnt_reg <= '0;
			tif.expired <= 1'b0;
		end else begin
			case (state_reg)
				RBPC_T_COUNT: begin
					cnt_reg <= cnt_reg + 24'h000001;
					if (cnt_reg == 24'(LIMIT - 1)) begin
						tif.expired <= 1'b1;
						state_reg <= RBPC_T_DONE;
					end else begin
						tif.expired <= 1'b0;
					end
				end
				RBPC_T_DONE: begin
					tif.expired <= 1'b0;
				end
				default: begin
					state_reg <= RBPC_T_COUNT;
					tif.expired <= 1'b0;
				end
			endcase
		end
	end

	// Independent count of cycles since the last restart, read only by a check.
	always_ff @(posedge aclk) begin
		if (!aresetn || tif.restart) begin
			run_reg <= '0;
		end else if (run_reg != 24'hFFFFFF) begin
			run_reg <= run_reg + 24'h000001;
		end
	end

	chk_full_idle: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.expired |-> run_reg >= 24'(LIMIT - 1))
		else $error("Idle expiry came before a full failsafe interval.");
endmodule : rbpc_idle_timer
`default_nettype wire

// ### rbpc_standby_filter.sv
// Standby filter: ignores short disabled pulses, leaves standby at once.
`timescale 1ns/1ps
`default_nettype none
`include "rbpc_defines.svh"
module rbpc_standby_filter (
	input wire logic aclk,
	input wire logic aresetn,
	rbpc_core_if.sby sif
);
	import rbpc_pkg::*;

	localparam logic [7:0] STANDBY_CYC = 8'(`RBPC_STANDBY_CYC);

	logic [7:0] cnt_reg;

	// A re-enable clears the count and standby in the same edge.
	always_ff @(posedge aclk) begin
		if (!aresetn || !sif.dis_req) begin
			cnt_reg <= 8'h00;
			sif.standby <= 1'b0;
		end else if (cnt_reg != STANDBY_CYC) begin
			cnt_reg <= cnt_reg + 8'h01;
			sif.standby <= (cnt_reg == STANDBY_CYC - 8'h01);
		end
	end
endmodule : rbpc_standby_filter
`default_nettype wire

// ### rbpc_top.sv
// Half-duplex bus node control with automatic bus-polarity correction.
`timescale 1ns/1ps
`default_nettype none
`include "rbpc_defines.svh"
// Functional notes
// - Polarity is judged only while listening with driver off.
// - A decision needs the bus idle, without transitions, for the whole failsafe time.
// - Correction starts straight out of reset, finishing inside 44 to 76 ms of idle.
// - The chosen polarity reaches receive and transmit paths together.
// - The chosen polarity is latched and held until the next decision.
// - After reset no inversion is applied.
// - Idle bus seen low at expiry selects inversion, receiver output goes high.
// - In corrected state transmit data is inverted before the driver.
// - The whole detection repeats after every reset.
// - An idle bus with proper failsafe bias reads high at the receiver.
// - Both enables tied: high drives, low receives.
// - Standby only with driver and receiver both disabled.
// - Receiver on while driving returns own transmitted data.
// - Standby only after both disabled for at least 300 ns.
// - Standby ends as soon as either side is enabled.
module rbpc_top #(
	parameter int unsigned IDLE_CYC = `RBPC_FAILSAFE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire rbpc_pkg::rbpc_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire rbpc_pkg::rbpc_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_bus_in,
	output logic rx_data_out,
	output logic rx_data_oe,
	output logic drv_data_out,
	output logic drv_oe,
	output logic standby_out
);
	import rbpc_pkg::*;

	// Address match shared by the read and write decoders.
	function automatic logic rbpc_addr_hit(input rbpc_addr_t addr, input rbpc_addr_t ofs);
		rbpc_addr_hit = (addr[7:2] == ofs[7:2]);
	endfunction : rbpc_addr_hit

	rbpc_core_if cif ();

	logic [2:0] ctrl_reg;
	logic pol_inv_reg;
	logic decided_reg;
	logic rx_prev_reg;
	logic aw_full_reg;
	logic w_full_reg;
	rbpc_addr_t aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [7:0] dis_run_reg;
	logic drive_enable;
	logic listen_enable_n;
	logic tx_data;
	logic listening;
	logic rx_edge;
	logic [31:0] status_word;

	assign drive_enable = ctrl_reg[`RBPC_CTRL_DRIVE_BIT];
	assign listen_enable_n = ctrl_reg[`RBPC_CTRL_LISTEN_N_BIT];
	assign tx_data = ctrl_reg[`RBPC_CTRL_TXD_BIT];

	// Listening means receiver on and driver off; nothing else is judged.
	assign listening = !drive_enable && !listen_enable_n;
	assign rx_edge = rx_bus_in ^ rx_prev_reg;

	// Timer restarts on any bus transition or whenever listening stops.
	assign cif.restart = !listening || rx_edge;
	// Standby request needs both sides off, which only separate enables allow.
	assign cif.dis_req = !drive_enable && listen_enable_n;

	rbpc_idle_timer #(
		.LIMIT(IDLE_CYC)
	) u_idle_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.tif(cif.tmr)
	);

	rbpc_standby_filter u_standby_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.sif(cif.sby)
	);

	// Previous bus level for transition detection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_prev_reg <= 1'b1;
		end else begin
			rx_prev_reg <= rx_bus_in;
		end
	end

	// Polarity latch: normal after reset, rewritten only at an idle expiry.
	// Every reset starts over from normal, so a reversed bus is found again.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pol_inv_reg <= 1'b0;
			decided_reg <= 1'b0;
		end else if (cif.expired) begin
			pol_inv_reg <= !rx_bus_in;
			decided_reg <= 1'b1;
		end
	end

	// Receive path; an idle biased bus yields high once polarity is right.
	// The receiver stays live while driving, so the node hears itself.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data_out <= 1'b1;
			rx_data_oe <= 1'b0;
		end else begin
			rx_data_out <= rx_bus_in ^ pol_inv_reg;
			rx_data_oe <= !listen_enable_n;
		end
	end

	// Transmit path shares the latch with the receive path.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drv_data_out <= 1'b1;
			drv_oe <= 1'b0;
			standby_out <= 1'b0;
		end else begin
			drv_data_out <= tx_data ^ pol_inv_reg;
			drv_oe <= drive_enable;
			// Standby drops on the very edge that sees an enable, so it outlives the disabled run by one cycle at most.
			standby_out <= cif.standby && cif.dis_req;
		end
	end

	// Write side: address and data are taken in either order, then answered.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RBPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= rbpc_addr_hit(aw_addr_reg, `RBPC_CTRL_OFS) ||
					rbpc_addr_hit(aw_addr_reg, `RBPC_STATUS_OFS) ?
					`RBPC_RESP_OKAY : `RBPC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Control register; reset leaves direction low so correction can begin at once.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `RBPC_CTRL_RESET;
		end else if (aw_full_reg && w_full_reg && !s_axi_bvalid &&
			rbpc_addr_hit(aw_addr_reg, `RBPC_CTRL_OFS) && w_strb_reg[0]) begin
			ctrl_reg <= w_data_reg[2:0];
		end
	end

	// Status word shows the live state of the corrector.
	always_comb begin
		status_word = 32'h00000000;
		status_word[`RBPC_STAT_RXD_BIT] = rx_data_out;
		status_word[`RBPC_STAT_INV_BIT] = pol_inv_reg;
		status_word[`RBPC_STAT_STANDBY_BIT] = standby_out;
		status_word[`RBPC_STAT_LISTEN_BIT] = listening;
		status_word[`RBPC_STAT_DECIDED_BIT] = decided_reg;
	end

	// Read side: one read in flight, answered the edge after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RBPC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			if (rbpc_addr_hit(s_axi_araddr, `RBPC_CTRL_OFS)) begin
				s_axi_rdata <= {29'h0000000, ctrl_reg};
				s_axi_rresp <= `RBPC_RESP_OKAY;
			end else if (rbpc_addr_hit(s_axi_araddr, `RBPC_STATUS_OFS)) begin
				s_axi_rdata <= status_word;
				s_axi_rresp <= `RBPC_RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RBPC_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Consecutive disabled cycles, read only by the standby delay check.
	always_ff @(posedge aclk) begin
		if (!aresetn || !cif.dis_req) begin
			dis_run_reg <= 8'h00;
		end else if (dis_run_reg != 8'hFF) begin
			dis_run_reg <= dis_run_reg + 8'h01;
		end
	end

	chk_listen_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.expired |-> $past(listening) && listening)
		else $error("Polarity judged while not listening.");

	chk_low_inverts: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.expired && !rx_bus_in |=> pol_inv_reg ##1 rx_data_out)
		else $error("Low idle bus did not select inversion.");

	chk_high_normal: assert property (@(posedge aclk) disable iff (!aresetn)
		cif.expired && rx_bus_in |=> !pol_inv_reg)
		else $error("High idle bus did not select normal polarity.");

	chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!cif.expired |=> $stable(pol_inv_reg))
		else $error("Polarity latch changed without a decision.");

	chk_tx_invert: assert property (@(posedge aclk) disable iff (!aresetn)
		pol_inv_reg && $stable(pol_inv_reg) |=> drv_data_out == !$past(tx_data))
		else $error("Transmit data not inverted in corrected state.");

	chk_paths_agree: assert property (@(posedge aclk) disable iff (!aresetn)
		$stable(pol_inv_reg) |=> (rx_data_out ^ $past(rx_bus_in)) ==
			(drv_data_out ^ $past(tx_data)))
		else $error("Receive and transmit paths disagree on polarity.");

	chk_standby_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		standby_out |-> dis_run_reg > 8'(`RBPC_STANDBY_CYC))
		else $error("Standby entered before the least disabled time.");

	chk_standby_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		!cif.dis_req |-> ##2 !standby_out)
		else $error("Standby not left after an enable.");

	chk_drive_dir: assert property (@(posedge aclk) disable iff (!aresetn)
		drive_enable [*2] |-> drv_oe ##0 !cif.standby)
		else $error("Driver not enabled while direction is high.");
endmodule : rbpc_top
`default_nettype wire

// ### rbpc_bus_model.sv
// Bus model: failsafe-biased line, a remote master and optionally crossed wires.
`timescale 1ns/1ps
`default_nettype none
module rbpc_bus_model (
	input wire logic swap,
	input wire logic mst_oe,
	input wire logic mst_bit,
	input wire logic drv_oe,
	input wire logic drv_data_out,
	output logic rx_bus_in,
	output logic mst_rx
);
	logic line;
	// Level at the master end; a released line never keeps its last driven value.
	always_comb begin
		if (drv_oe) begin
			line = drv_data_out ^ swap;
		end else if (mst_oe) begin
			line = mst_bit;
		end else begin
			line = 1'h1;
		end
	end
	// Crossed wires invert everything that passes between the two ends.
	assign rx_bus_in = line ^ swap;
	assign mst_rx = line;
endmodule : rbpc_bus_model
`default_nettype wire

// ### test_rs485_bus_polarity_corrector.sv
// Self-checking bench for the polarity corrector and its bus model.
`timescale 1ns/1ps
`default_nettype none
`include "rbpc_defines.svh"
module test_rs485_bus_polarity_corrector;
	import rbpc_pkg::*;
	localparam int unsigned IDLE = 50;
	typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} rbpc_exp_s;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	rbpc_addr_t awaddr = 8'h00;
	rbpc_addr_t araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic swap = 1'h1, mst_oe = 1'h0, mst_bit = 1'h1;
	logic awready, wready, bvalid, arready, rvalid, rx_bus_in, rx_data_out, rx_data_oe;
	logic drv_data_out, drv_oe, standby_out, mst_rx;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int mismatches = 0;
	int check_count = 0;
	int seed = 32'h6867;
	rbpc_exp_s expq[$];
	rbpc_exp_s cur;

	rbpc_top #(.IDLE_CYC(IDLE)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_bus_in(rx_bus_in), .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe),
		.drv_data_out(drv_data_out), .drv_oe(drv_oe), .standby_out(standby_out));
	rbpc_bus_model bus_u (.swap(swap), .mst_oe(mst_oe), .mst_bit(mst_bit), .drv_oe(drv_oe),
		.drv_data_out(drv_data_out), .rx_bus_in(rx_bus_in), .mst_rx(mst_rx));

	// Free-running 250 MHz clock.
	initial begin
		forever #2 aclk = ~aclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Address and data are offered together and released one by one as each is taken.
	task automatic axi_wr(input rbpc_addr_t a, input logic [31:0] d, input logic [1:0] resp);
		logic da, dw, ta, tw;
		rbpc_exp_s e;
		e = '{resp, 32'h0, 32'h0};
		expq.push_back(e);
		da = 1'h0;
		dw = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = !da && awready;
			tw = !dw && wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			da = da | ta;
			dw = dw | tw;
		end
		@(negedge aclk);
		while (!bvalid) @(negedge aclk);
		@(posedge aclk);
		bready <= 1'h0;
	endtask : axi_wr

	task automatic axi_rd(input rbpc_addr_t a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] resp);
		rbpc_exp_s e;
		e = '{resp, d, m};
		expq.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		@(negedge aclk);
		while (!arready) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'h0;
		@(negedge aclk);
		while (!rvalid) @(negedge aclk);
		@(posedge aclk);
		rready <= 1'h0;
	endtask : axi_rd

	task automatic stat(input logic [31:0] d, input logic [31:0] m);
		axi_rd(`RBPC_STATUS_OFS, d, m, `RBPC_RESP_OKAY);
	endtask : stat

	task automatic do_reset(input logic s);
		@(posedge aclk);
		aresetn <= 1'h0;
		swap <= s;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
	endtask : do_reset

	// Fresh start on a quiet bus: uncorrected at first, decided after one idle run.
	task automatic fresh(input logic s);
		do_reset(s);
		repeat (3) @(posedge aclk);
		stat({27'h0, 1'h0, 1'h1, 1'h0, 1'h0, ~s}, 32'h1B);
		// The remote master keeps its driver off for longer than the idle time.
		repeat (IDLE + 20) @(posedge aclk);
		stat({27'h0, 1'h1, 1'h1, 1'h0, s, 1'h1}, 32'h1B);
	endtask : fresh

	// Each answer on the bus retires the oldest expectation noted by the driver.
	always @(posedge aclk) begin
		if ((bvalid && bready) || (rvalid && rready)) begin
			cur = expq.pop_front();
			check({30'h0, rvalid ? rresp : bresp}, {30'h0, cur.resp});
			if (rvalid) check(rdata & cur.mask, cur.data);
		end
	end

	// Watchdog: the whole run needs a few thousand cycles at most.
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		test_done();
	end

	initial begin
		logic tx;
		logic [31:0] d;
		fresh(1'h1);
		// Random transmit bits; upper data bits are random too and must be ignored.
		repeat (6) begin
			d = $random(seed);
			tx = d[2];
			d[1:0] = 2'h1;
			axi_wr(`RBPC_CTRL_OFS, d, `RBPC_RESP_OKAY);
			repeat (2) @(negedge aclk);
			check({31'h0, drv_oe}, 32'h1);
			check({31'h0, drv_data_out}, {31'h0, ~tx});
			check({31'h0, mst_rx}, {31'h0, tx});
			check({31'h0, rx_data_out}, {31'h0, tx});
		end
		// A long steady high while driving would flip the latch if the timer ran.
		axi_wr(`RBPC_CTRL_OFS, 32'h1, `RBPC_RESP_OKAY);
		repeat (2 * IDLE) @(posedge aclk);
		stat(32'h12, 32'h1A);
		axi_wr(`RBPC_CTRL_OFS, 32'h6, `RBPC_RESP_OKAY);
		axi_wr(`RBPC_CTRL_OFS, 32'h4, `RBPC_RESP_OKAY);
		repeat (100) @(posedge aclk);
		stat(32'h08, 32'h0C);
		axi_wr(`RBPC_CTRL_OFS, 32'h7, `RBPC_RESP_OKAY);
		repeat (100) @(posedge aclk);
		stat(32'h00, 32'h0C);
		axi_wr(`RBPC_CTRL_OFS, 32'h6, `RBPC_RESP_OKAY);
		repeat (50) @(posedge aclk);
		stat(32'h00, 32'h04);
		repeat (40) @(posedge aclk);
		stat(32'h04, 32'h0C);
		// Pins are looked at mid-cycle, away from the edge that launches them.
		@(negedge aclk);
		check({31'h0, rx_data_oe}, 32'h0);
		check({31'h0, standby_out}, 32'h1);
		axi_wr(`RBPC_CTRL_OFS, 32'h4, `RBPC_RESP_OKAY);
		stat(32'h08, 32'h0C);
		// Byte lane 0 disabled leaves the control word alone; status is read-only.
		wstrb <= 4'hE;
		axi_wr(`RBPC_CTRL_OFS, 32'h1, `RBPC_RESP_OKAY);
		wstrb <= 4'hF;
		axi_wr(`RBPC_STATUS_OFS, 32'h1F, `RBPC_RESP_OKAY);
		axi_rd(`RBPC_CTRL_OFS, 32'h4, 32'h7, `RBPC_RESP_OKAY);
		axi_rd(8'h10, 32'h0, 32'hFFFFFFFF, `RBPC_RESP_SLVERR);
		axi_wr(8'h20, 32'h7, `RBPC_RESP_SLVERR);
		fresh(1'h0);
		// Traffic in runs shorter than the failsafe time must never lead to a decision.
		fork
			do_reset(1'h1);
			begin
				mst_oe <= 1'h1;
				repeat (12) begin
					repeat (20) @(posedge aclk);
					mst_bit <= ~mst_bit;
				end
				mst_oe <= 1'h0;
			end
		join
		stat(32'h00, 32'h10);
		fresh(1'h1);
		test_done();
	end
endmodule : test_rs485_bus_polarity_corrector
`default_nettype wire
